// File: design/rcs_buf.v
`timescale 1ns/10ps
module rcs_buf #(
  parameter DW = 8,
  parameter AW = 4
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data_q
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Storage has no reset, nor has the read register; a read returns whatever mem holds at rd_addr
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data_q <= mem[rd_addr];
    end
  end
endmodule

// File: design/rcs_map.vh
`ifndef RCS_MAP_VH
`define RCS_MAP_VH

// -------------------------------------------------------------
// Characters of the command language
// -------------------------------------------------------------
`define RCS_CH_TERM 8'h0A
`define RCS_CH_SEP 8'h3B
`define RCS_CH_QRY 8'h3F
`define RCS_CH_COMMON 8'h2A
`define RCS_CH_SET_A 8'h46
`define RCS_CH_SET_B 8'h4C
`define RCS_CH_OPC 8'h4F
`define RCS_CH_OPCQ 8'h51
`define RCS_CH_WAIT 8'h57
`define RCS_CH_TRIG 8'h54
`define RCS_CH_ZERO 8'h30
`define RCS_CH_ONE 8'h31
`define RCS_CH_NINE 8'h39

// -------------------------------------------------------------
// Settings limits
// -------------------------------------------------------------
`define RCS_VAL_W 4
`define RCS_VAL_MAX 4'h7
`define RCS_SUM_MAX 5'h0C
`define RCS_VAL_RST 4'h0

// -------------------------------------------------------------
// Event status and status byte bits
// -------------------------------------------------------------
`define RCS_ESR_OPC 0
`define RCS_ESR_QYE 2
`define RCS_ESR_EXE 4
`define RCS_ESR_CME 5
`define RCS_STB_MAV 4
`define RCS_STB_ESB 5
`define RCS_STB_MSS 6
`define RCS_BYTE_RST 8'h00

`endif

// File: design/rcs_top.v
`timescale 1ns/10ps
`include "rcs_map.vh"
module rcs_top #(
  parameter AW = 4
) (
  input wire clk,
  input wire rst_b,
  input wire rx_valid,
  input wire [7:0] rx_data,
  output reg rx_ready_q,
  input wire dcl_pin,
  input wire talk,
  output reg out_valid_q,
  output reg [7:0] out_data_q,
  input wire out_ready,
  output reg hw_apply_q,
  output reg [`RCS_VAL_W-1:0] hw_a_q,
  output reg [`RCS_VAL_W-1:0] hw_b_q,
  input wire hw_ok,
  input wire hw_done,
  output reg trig_q,
  input wire [7:0] ese,
  input wire [7:0] sre,
  input wire esr_clr,
  output reg [7:0] esr_q,
  output reg [7:0] stb_q,
  output reg srq_q
);
  localparam DEPTH = 1 << AW;
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_DECODE = 4'h2;
  localparam [3:0] ST_WAIT = 4'h4;
  localparam [3:0] ST_REPLY = 4'h8;
  localparam [4:0] PS_CMD = 5'h01;
  localparam [4:0] PS_VAL = 5'h02;
  localparam [4:0] PS_QRY = 5'h04;
  localparam [4:0] PS_COM = 5'h08;
  localparam [4:0] PS_SKIP = 5'h10;
  function is_setting;
    input [7:0] c;
    begin
      is_setting = (c == `RCS_CH_SET_A) || (c == `RCS_CH_SET_B);
    end
  endfunction
  // -------------------------------------------------------------
  // Device clear synchroniser
  // -------------------------------------------------------------
  reg dcl_s1_q, dcl_s2_q, dcl_s3_q, dcl_lvl_q;
  wire dcl_evt = dcl_s2_q & dcl_s3_q & ~dcl_lvl_q;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dcl_s1_q <= 1'b0;
      dcl_s2_q <= 1'b0;
      dcl_s3_q <= 1'b0;
      dcl_lvl_q <= 1'b0;
    end else begin
      dcl_s1_q <= dcl_pin;
      dcl_s2_q <= dcl_s1_q;
      dcl_s3_q <= dcl_s2_q;
      if (dcl_s2_q == dcl_s3_q) begin
        dcl_lvl_q <= dcl_s3_q;
      end
    end
  end
  // -------------------------------------------------------------
  // Input buffer
  // -------------------------------------------------------------
  reg [AW-1:0] wr_ptr_q, rd_ptr_q;
  reg [AW:0] cnt_q;
  reg [AW:0] lines_q;
  reg [3:0] st_q;
  wire [7:0] ch;
  wire push = rx_valid & rx_ready_q & ~dcl_evt;
  wire full = (cnt_q == DEPTH[AW:0]);
  // Recognition is told to run on a whole line or a full buffer
  wire avail = (lines_q != {(AW+1){1'b0}}) | full;
  wire pop = (st_q == ST_IDLE) & (cnt_q != {(AW+1){1'b0}}) & avail
    & ~dcl_evt;
  wire [AW:0] cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  wire push_term = push & (rx_data == `RCS_CH_TERM);
  wire pop_term = (st_q == ST_DECODE) & (ch == `RCS_CH_TERM);
  rcs_buf #(.DW(8), .AW(AW)) u_buf (
    .clk(clk),
    .wr_en(push),
    .wr_addr(wr_ptr_q),
    .wr_data(rx_data),
    .rd_en(pop),
    .rd_addr(rd_ptr_q),
    .rd_data_q(ch)
  );
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      lines_q <= {(AW+1){1'b0}};
      rx_ready_q <= 1'b0;
    end else if (dcl_evt) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      lines_q <= {(AW+1){1'b0}};
      rx_ready_q <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      cnt_q <= cnt_d;
      lines_q <= lines_q + {{AW{1'b0}}, push_term}
        - {{AW{1'b0}}, pop_term};
      // Traffic keeps flowing while earlier lines execute
      rx_ready_q <= (cnt_d != DEPTH[AW:0]);
    end
  end
  // -------------------------------------------------------------
  // Recognition, settings store and synchronisation
  // -------------------------------------------------------------
  reg [4:0] ps_q;
  reg sel_b_q, dirty_q, busy_q, opc_pend_q, wait_reply_q, wait_trig_q;
  reg [`RCS_VAL_W-1:0] pend_a_q, pend_b_q;
  reg [7:0] reply_q;
  reg set_opc, set_cme, set_exe;
  wire [`RCS_VAL_W-1:0] digit = ch[`RCS_VAL_W-1:0];
  wire is_digit = (ch >= `RCS_CH_ZERO) && (ch <= `RCS_CH_NINE);
  wire [4:0] sum = {1'b0, pend_a_q} + {1'b0, pend_b_q};
  wire compat = hw_ok & (sum <= `RCS_SUM_MAX);
  // Settled: nothing applied that hardware has not acknowledged
  wire settled = ~busy_q & ~hw_apply_q;
  wire line_end = dcl_evt | pop_term;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_IDLE;
      ps_q <= PS_CMD;
      sel_b_q <= 1'b0;
      dirty_q <= 1'b0;
      busy_q <= 1'b0;
      opc_pend_q <= 1'b0;
      wait_reply_q <= 1'b0;
      wait_trig_q <= 1'b0;
      pend_a_q <= `RCS_VAL_RST;
      pend_b_q <= `RCS_VAL_RST;
      hw_a_q <= `RCS_VAL_RST;
      hw_b_q <= `RCS_VAL_RST;
      hw_apply_q <= 1'b0;
      trig_q <= 1'b0;
      reply_q <= `RCS_BYTE_RST;
      set_opc <= 1'b0;
      set_cme <= 1'b0;
      set_exe <= 1'b0;
    end else begin
      hw_apply_q <= 1'b0;
      trig_q <= 1'b0;
      set_opc <= 1'b0;
      set_cme <= 1'b0;
      set_exe <= 1'b0;
      if (hw_apply_q) begin
        busy_q <= 1'b1;
      end else if (hw_done) begin
        busy_q <= 1'b0;
      end
      if (opc_pend_q && settled) begin
        opc_pend_q <= 1'b0;
        set_opc <= 1'b1;
      end
      if (line_end) begin
        // Line end: check the pending set as a whole, then commit
        ps_q <= PS_CMD;
        if (dirty_q) begin
          dirty_q <= 1'b0;
          if (compat) begin
            hw_a_q <= pend_a_q;
            hw_b_q <= pend_b_q;
            hw_apply_q <= 1'b1;
          end else begin
            set_exe <= 1'b1;
            pend_a_q <= hw_a_q;
            pend_b_q <= hw_b_q;
          end
        end
      end
      if (dcl_evt) begin
        st_q <= ST_IDLE;
        wait_reply_q <= 1'b0;
        wait_trig_q <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (pop) begin
              st_q <= ST_DECODE;
            end
          end
          ST_DECODE: begin
            // Recognition is free for the next character at once, except after a query or *Q, *W or *T
            st_q <= ST_IDLE;
            if (ch == `RCS_CH_SEP) begin
              ps_q <= PS_CMD;
            end else if (ch != `RCS_CH_TERM) begin
              case (ps_q)
                PS_CMD: begin
                  if (is_setting(ch)) begin
                    sel_b_q <= (ch == `RCS_CH_SET_B);
                    ps_q <= PS_VAL;
                  end else if (ch == `RCS_CH_QRY) begin
                    ps_q <= PS_QRY;
                  end else if (ch == `RCS_CH_COMMON) begin
                    ps_q <= PS_COM;
                  end else begin
                    set_cme <= 1'b1;
                    ps_q <= PS_SKIP;
                  end
                end
                PS_VAL: begin
                  ps_q <= PS_CMD;
                  if (!is_digit) begin
                    set_cme <= 1'b1;
                    ps_q <= PS_SKIP;
                  end else if (digit > `RCS_VAL_MAX) begin
                    set_exe <= 1'b1;
                  end else begin
                    // No cross check here; sum is judged at line end
                    dirty_q <= 1'b1;
                    if (sel_b_q) begin
                      pend_b_q <= digit;
                    end else begin
                      pend_a_q <= digit;
                    end
                  end
                end
                PS_QRY: begin
                  ps_q <= PS_CMD;
                  if (is_setting(ch)) begin
                    reply_q <= `RCS_CH_ZERO + {4'h0,
                      (ch == `RCS_CH_SET_B) ? pend_b_q : pend_a_q};
                    st_q <= ST_REPLY;
                  end else begin
                    set_cme <= 1'b1;
                    ps_q <= PS_SKIP;
                  end
                end
                PS_COM: begin
                  ps_q <= PS_CMD;
                  if (ch == `RCS_CH_OPC) begin
                    opc_pend_q <= 1'b1;
                  end else if (ch == `RCS_CH_OPCQ) begin
                    wait_reply_q <= 1'b1;
                    st_q <= ST_WAIT;
                  end else if (ch == `RCS_CH_WAIT) begin
                    st_q <= ST_WAIT;
                  end else if (ch == `RCS_CH_TRIG) begin
                    wait_trig_q <= 1'b1;
                    st_q <= ST_WAIT;
                  end else begin
                    set_cme <= 1'b1;
                    ps_q <= PS_SKIP;
                  end
                end
                PS_SKIP: ps_q <= PS_SKIP;
                default: ps_q <= PS_CMD;
              endcase
            end
          end
          ST_WAIT: begin
            if (settled && !opc_pend_q) begin
              wait_trig_q <= 1'b0;
              trig_q <= wait_trig_q;
              if (wait_reply_q) begin
                wait_reply_q <= 1'b0;
                set_opc <= 1'b1;
                reply_q <= `RCS_CH_ONE;
                st_q <= ST_REPLY;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_REPLY: begin
            if (!out_valid_q) begin
              st_q <= ST_IDLE;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end
  // -------------------------------------------------------------
  // Output buffer
  // -------------------------------------------------------------
  wire load_out = (st_q == ST_REPLY) & ~out_valid_q & ~dcl_evt;
  wire reply_pend = (st_q == ST_REPLY) | ((st_q == ST_WAIT) & wait_reply_q);
  reg set_qye;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid_q <= 1'b0;
      out_data_q <= `RCS_BYTE_RST;
      set_qye <= 1'b0;
    end else begin
      set_qye <= talk & ~out_valid_q & ~reply_pend;
      if (load_out) begin
        out_valid_q <= 1'b1;
        out_data_q <= reply_q;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
    end
  end
  // -------------------------------------------------------------
  // Event status, status byte and service request
  // -------------------------------------------------------------
  reg [7:0] ev;
  reg [7:0] stb_d;
  always @* begin
    ev = `RCS_BYTE_RST;
    ev[`RCS_ESR_OPC] = set_opc;
    ev[`RCS_ESR_QYE] = set_qye;
    ev[`RCS_ESR_EXE] = set_exe;
    ev[`RCS_ESR_CME] = set_cme;
    stb_d = `RCS_BYTE_RST;
    stb_d[`RCS_STB_MAV] = out_valid_q;
    stb_d[`RCS_STB_ESB] = |(esr_q & ese);
    stb_d[`RCS_STB_MSS] = |(stb_d & sre);
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      esr_q <= `RCS_BYTE_RST;
      stb_q <= `RCS_BYTE_RST;
      srq_q <= 1'b0;
    end else begin
      // A new event wins over a clear in the same cycle
      esr_q <= (esr_clr ? `RCS_BYTE_RST : esr_q) | ev;
      stb_q <= stb_d;
      srq_q <= |(stb_d & ~stb_q & sre & ~(8'h01 << `RCS_STB_MSS));
    end
  end
endmodule

// File: tb/rcs_hw_model.sv
`timescale 1ns/10ps
module rcs_hw_model #(
  parameter SETTLE = 6
) (
  input logic clk,
  input logic rst_b,
  input logic hw_apply_q,
  input logic slow,
  output logic hw_done
);
  int cnt_q;
  // Settles never in the apply cycle itself
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 0;
      hw_done <= 1'b0;
    end else begin
      hw_done <= (cnt_q == 1);
      if (hw_apply_q) begin
        cnt_q <= slow ? SETTLE : 1;
      end else if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
endmodule

// File: tb/rcs_properties.sv
`timescale 1ns/10ps
`include "rcs_map.vh"
module rcs_properties #(
  parameter AW = 4
) (
  input logic clk,
  input logic rst_b,
  input logic out_ready,
  input logic out_valid_q,
  input logic [7:0] out_data_q,
  input logic hw_apply_q,
  input logic [`RCS_VAL_W-1:0] hw_a_q,
  input logic [`RCS_VAL_W-1:0] hw_b_q,
  input logic [7:0] ese,
  input logic [7:0] sre,
  input logic esr_clr,
  input logic [7:0] esr_q,
  input logic [7:0] stb_q,
  input logic srq_q
);
  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_apply_one_cycle: assert property (
    hw_apply_q |=> !hw_apply_q) else $error("apply pulse too long");
  a_hw_only_on_apply: assert property (
    (hw_a_q != $past(hw_a_q) || hw_b_q != $past(hw_b_q)) |-> hw_apply_q)
    else $error("hardware value moved without apply");
  a_value_in_range: assert property (
    hw_a_q <= `RCS_VAL_MAX && hw_b_q <= `RCS_VAL_MAX)
    else $error("committed value out of range");
  a_sum_compatible: assert property (
    hw_apply_q |-> ({1'b0, hw_a_q} + {1'b0, hw_b_q}) <= `RCS_SUM_MAX)
    else $error("incompatible set committed");
  a_esb_summary: assert property (
    stb_q[`RCS_STB_ESB] == |($past(esr_q) & $past(ese)))
    else $error("event summary bit wrong");
  a_srq_on_rise: assert property (
    srq_q |-> |(stb_q & ~$past(stb_q) & sre & 8'hBF))
    else $error("service request without enabled rise");
  a_esr_sticky: assert property (
    |($past(esr_q) & ~esr_q) |-> $past(esr_clr))
    else $error("event bit lost without clear");
  a_reply_holds: assert property (
    out_valid_q && !out_ready |=> out_valid_q && $stable(out_data_q))
    else $error("reply byte dropped before taken");
endmodule

bind rcs_top rcs_properties #(.AW(AW)) u_props (
  .clk(clk), .rst_b(rst_b), .out_ready(out_ready),
  .out_valid_q(out_valid_q), .out_data_q(out_data_q),
  .hw_apply_q(hw_apply_q), .hw_a_q(hw_a_q), .hw_b_q(hw_b_q),
  .ese(ese), .sre(sre), .esr_clr(esr_clr), .esr_q(esr_q),
  .stb_q(stb_q), .srq_q(srq_q));

// File: tb/test_remote_command_sequencer.sv
`timescale 1ns/10ps
module test_remote_command_sequencer;
  logic clk, rst_b, rx_valid, dcl_pin, talk, out_ready, hw_ok;
  logic hw_done, esr_clr, slow, arm, full_seen;
  logic [7:0] rx_data, ese, sre, d;
  logic rx_ready_q, out_valid_q, hw_apply_q, trig_q, srq_q;
  logic [7:0] out_data_q, esr_q, stb_q;
  logic [3:0] hw_a_q, hw_b_q;
  int failures, checks, apply_n, trig_n, srq_n, k;
  string rl[4] = '{"F3", "L5", "F7;L2", "L4;F1;L0"};
  logic [3:0] ra[4] = '{4'h3, 4'h3, 4'h7, 4'h1};
  logic [3:0] rb[4] = '{4'h0, 4'h5, 4'h2, 4'h0};

  rcs_top #(.AW(4)) dut_u (.clk(clk), .rst_b(rst_b),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready_q(rx_ready_q),
    .dcl_pin(dcl_pin), .talk(talk), .out_valid_q(out_valid_q),
    .out_data_q(out_data_q), .out_ready(out_ready),
    .hw_apply_q(hw_apply_q), .hw_a_q(hw_a_q), .hw_b_q(hw_b_q),
    .hw_ok(hw_ok), .hw_done(hw_done), .trig_q(trig_q), .ese(ese),
    .sre(sre), .esr_clr(esr_clr), .esr_q(esr_q), .stb_q(stb_q),
    .srq_q(srq_q));
  rcs_hw_model hw_u (.clk(clk), .rst_b(rst_b),
    .hw_apply_q(hw_apply_q), .slow(slow), .hw_done(hw_done));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (hw_apply_q === 1'b1) apply_n <= apply_n + 1;
    if (trig_q === 1'b1) trig_n <= trig_n + 1;
    if (srq_q === 1'b1) srq_n <= srq_n + 1;
    if (arm && rx_ready_q === 1'b0) full_seen <= 1'b1;
  end

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task tally_and_finish;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task tmo;
    failures++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    tally_and_finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task send_byte(input logic [7:0] c);
    int n;
    rx_valid <= 1'b1;
    rx_data <= c;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rx_ready_q !== 1'b1 && n < 400);
    if (n >= 400) tmo;
  endtask

  task send_line(input string s);
    for (int i = 0; i < s.len(); i++) send_byte(s[i]);
    send_byte(8'h0A);
    rx_valid <= 1'b0;
  endtask

  task wait_apply;
    int n;
    n = apply_n;
    for (int i = 0; i < 600 && apply_n == n; i++) @(posedge clk);
    if (apply_n == n) tmo;
  endtask

  task wait_esr(input int b);
    for (int i = 0; i < 600 && esr_q[b] !== 1'b1; i++) @(posedge clk);
    if (esr_q[b] !== 1'b1) tmo;
  endtask

  // Reply is a single byte with no terminator; out_ready is still held 20 cycles
  task get_reply(output logic [7:0] r);
    for (int i = 0; i < 600 && out_valid_q !== 1'b1; i++) @(posedge clk);
    if (out_valid_q !== 1'b1) tmo;
    r = out_data_q;
    out_ready <= 1'b1;
    repeat (20) @(posedge clk);
    out_ready <= 1'b0;
  endtask

  task clr;
    esr_clr <= 1'b1;
    @(posedge clk);
    esr_clr <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------
  initial begin
    rst_b = 1'b0; rx_valid = 1'b0; rx_data = 8'h00; dcl_pin = 1'b0;
    talk = 1'b0; out_ready = 1'b0; hw_ok = 1'b1; esr_clr = 1'b0;
    ese = 8'h01; sre = 8'h20; slow = 1'b0; arm = 1'b0;
    full_seen = 1'b0; failures = 0; checks = 0;
    apply_n = 0; trig_n = 0; srq_n = 0;
    repeat (4) @(posedge clk);
    chk({7'h00, rx_ready_q}, 8'h00);
    chk(esr_q, 8'h00);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      send_line(rl[i]);
      wait_apply;
      chk({4'h0, hw_a_q}, {4'h0, ra[i]});
      chk({4'h0, hw_b_q}, {4'h0, rb[i]});
    end
    send_byte("F");
    send_byte("5");
    rx_valid <= 1'b0;
    repeat (20) @(posedge clk);
    chk({4'h0, hw_a_q}, 8'h01);
    send_line("");
    wait_apply;
    chk({4'h0, hw_a_q}, 8'h05);
    clr;
    send_line("F9");
    wait_esr(4);
    chk({4'h0, hw_a_q}, 8'h05);
    clr;
    slow <= 1'b1;
    send_line("F7;L7");
    wait_esr(4);
    chk({hw_a_q, hw_b_q}, 8'h50);
    clr;
    send_line("X;L6");
    wait_apply;
    chk({4'h0, hw_b_q}, 8'h06);
    chk({7'h00, esr_q[5]}, 8'h01);
    send_line("?L");
    get_reply(d);
    chk(d, 8'h36);
    clr;
    talk <= 1'b1;
    @(posedge clk);
    talk <= 1'b0;
    wait_esr(2);
    chk({7'h00, out_valid_q}, 8'h00);
    send_byte("F");
    send_byte("4");
    rx_valid <= 1'b0;
    dcl_pin <= 1'b1;
    repeat (3) @(posedge clk);
    dcl_pin <= 1'b0;
    repeat (10) @(posedge clk);
    send_line("L1");
    wait_apply;
    chk({hw_a_q, hw_b_q}, 8'h51);
    arm <= 1'b1;
    send_line(";;;;;;;;;;;;;;;;;;L3");
    wait_apply;
    chk({4'h0, hw_b_q}, 8'h03);
    chk({7'h00, full_seen}, 8'h01);
    k = trig_n;
    send_line("*W;*T");
    repeat (60) @(posedge clk);
    chk(trig_n - k, 8'h01);
    clr;
    send_line("F3");
    send_line("*Q");
    get_reply(d);
    chk(d, 8'h31);
    chk({4'h0, hw_a_q}, 8'h03);
    chk({7'h00, esr_q[0]}, 8'h01);
    clr;
    // Hardware refuses a set that is fine on its own
    hw_ok <= 1'b0;
    send_line("F2");
    wait_esr(4);
    chk({hw_a_q, hw_b_q}, 8'h33);
    hw_ok <= 1'b1;
    k = srq_n;
    send_line("*O");
    wait_esr(0);
    repeat (3) @(posedge clk);
    chk({7'h00, stb_q[5]}, 8'h01);
    chk(stb_q, 8'h60);
    chk(srq_n - k, 8'h01);
    tally_and_finish;
  end
endmodule
